/* File: hw/pmn_pkg.sv */
`default_nettype none
package pmn_pkg;
  typedef logic [31:0] pmnWord_t;
  typedef logic [3:0] pmnNibble_t;
  typedef logic [1:0] pmnTrans_t;
  typedef logic [2:0] pmnSize_t;

  // register byte addresses
  localparam pmnWord_t PMN_CTRL_ADDR = 32'h0000_0000;
  localparam pmnWord_t PMN_PRESET_ADDR = 32'h0000_0004;
  localparam pmnWord_t PMN_STATUS_ADDR = 32'h0000_0008;
  localparam pmnWord_t PMN_COUNT_ADDR = 32'h0000_000C;
  localparam int PMN_ADDR_BITS = 4;

  // control register fields
  localparam int PMN_CTRL_LOADN = 0;
  localparam int PMN_CTRL_CLEARN = 1;
  localparam int PMN_CTRL_DECIMAL = 2;
  localparam int PMN_CTRL_GATEHOLD = 3;
  localparam int PMN_CTRL_BUSLOW = 4;
  localparam int PMN_CTRL_BITS = 5;
  localparam logic [4:0] PMN_CTRL_RESET = 5'h03;

  // status register fields
  localparam int PMN_STAT_TC = 0;
  localparam int PMN_STAT_GATE = 1;
  localparam int PMN_STAT_CLK = 2;

  localparam int PMN_STAGES = 3;
  localparam int PMN_SYNC_DEPTH = 3;
  localparam pmnNibble_t PMN_DEC_MAX = 4'h9;
  localparam pmnNibble_t PMN_BIN_MAX = 4'hF;
  localparam pmnNibble_t PMN_COUNT_RESET = 4'h0;
  localparam pmnTrans_t PMN_HTRANS_NONSEQ = 2'h2;

  // decimal stage drops the top preset bit above nine
  function automatic pmnNibble_t pmnPresetMask(input pmnNibble_t v,
                                               input logic dec);
    pmnPresetMask = (dec && v > PMN_DEC_MAX) ? {1'b0, v[2:0]} : v;
  endfunction

  // one count down, wrapping below zero to the stage maximum
  function automatic pmnNibble_t pmnDecWrap(input pmnNibble_t v,
                                            input logic dec);
    if (v == PMN_COUNT_RESET)
      pmnDecWrap = dec ? PMN_DEC_MAX : PMN_BIN_MAX;
    else
      pmnDecWrap = v - 4'h1;
  endfunction
endpackage
`default_nettype wire

/* File: hw/pmn_stage.sv */
`default_nettype none
module pmn_stage
  import pmn_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic decimalMode,
  input wire logic loadN,
  input wire logic clearN,
  input wire logic stepEn,
  input wire logic reloadEn,
  input wire pmn_pkg::pmnNibble_t presetVal,
  output pmn_pkg::pmnNibble_t count_r,
  output logic isZero
);
  always_ff @(posedge clock)
  begin
    if (rst)
      count_r <= PMN_COUNT_RESET;
    else if (!loadN)
    begin
      // a held load also holds the count still
      if (!clearN)
        count_r <= PMN_COUNT_RESET; // see RULE15
      else
        count_r <= pmnPresetMask(presetVal, decimalMode); // see RULE3
    end
    else if (reloadEn)
      count_r <= pmnPresetMask(presetVal, decimalMode); // see RULE13
    else if (stepEn)
      count_r <= pmnDecWrap(count_r, decimalMode); // see RULE4
  end

  assign isZero = (count_r == PMN_COUNT_RESET);
endmodule
`default_nettype wire

/* File: hw/pmn_counter.sv */
// Behaviour
// RULE1: controller presents modulus on preset inputs
// RULE2: decimal stage drops top bit above nine
// RULE3: low parallel load copies preset into count
// RULE4: each counted rising edge decrements the count
// RULE5: zero raises tc; reload when gate falls
// RULE6: one tc pulse per N input clocks
// RULE7: preset only acts in zero state
// RULE8: load pulse then count from new value
// RULE9: suppressed reload lets stages wrap freely
// RULE10: cascade ties gates to clock, shared tc
// RULE11: cascade modulus weights powers of base
// RULE12: zero lower stage wraps, borrows from next
// RULE13: all stages zero then reload together
// RULE14: counting starts first rising edge after load
// RULE15: clear with load forces zero, stops count
// RULE16: shared tc is AND of stage zero flags
//
// Register access over AHB-Lite and the register offsets were decided locally.
`default_nettype none
module pmn_counter
  import pmn_pkg::*;
#(
  parameter int STAGES = PMN_STAGES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire pmn_pkg::pmnWord_t haddr,
  input wire pmn_pkg::pmnTrans_t htrans,
  input wire logic hwrite,
  input wire pmn_pkg::pmnSize_t hsize,
  input wire pmn_pkg::pmnWord_t hwdata,
  input wire logic hready,
  output pmn_pkg::pmnWord_t hrdata_r,
  output logic hreadyout_r,
  output logic hresp_r,
  input wire logic countClkPin,
  input wire logic gatePin,
  output logic terminalCount_r,
  output logic [4*STAGES-1:0] countOut_r
);
  import pmn_pkg::*;

  // bus side state
  logic [PMN_CTRL_BITS-1:0] ctrl_r;
  logic [4*STAGES-1:0] preset_r;
  logic wrPend_r;
  logic [PMN_ADDR_BITS-1:0] wrAddr_r;
  logic accept;
  pmnWord_t readMux;

  // pin side state
  logic [PMN_SYNC_DEPTH-1:0] clkSync_r;
  logic [PMN_SYNC_DEPTH-1:0] gateSync_r;
  logic clkLvl_r;
  logic gateLvl_r;
  logic clkRise;

  // counting chain
  logic [4*STAGES-1:0] countVec;
  logic [4*STAGES-1:0] presetEff;
  logic [STAGES-1:0] stageZero;
  logic [STAGES:0] lowerZero;
  logic allZero;
  logic gateHigh;
  logic reloadEn;
  logic loadN;
  logic clearN;
  logic decimalMode;

  assign loadN = ctrl_r[PMN_CTRL_LOADN];
  assign clearN = ctrl_r[PMN_CTRL_CLEARN];
  assign decimalMode = ctrl_r[PMN_CTRL_DECIMAL];

  // zero wait states: answer always in the cycle after the address phase
  assign accept = hsel && hready && htrans == PMN_HTRANS_NONSEQ;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
    end
    else if (hready)
    begin
      wrPend_r <= accept && hwrite;
      wrAddr_r <= haddr[PMN_ADDR_BITS-1:0];
    end
  end

  // control register; load and clear are held levels, not strobes
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_r <= PMN_CTRL_RESET;
    else if (wrPend_r && wrAddr_r == PMN_CTRL_ADDR[PMN_ADDR_BITS-1:0])
      ctrl_r <= hwdata[PMN_CTRL_BITS-1:0]; // see RULE8
  end

  // preset may change at any time, it only acts at load or zero
  always_ff @(posedge clock)
  begin
    if (rst)
      preset_r <= '0;
    else if (wrPend_r && wrAddr_r == PMN_PRESET_ADDR[PMN_ADDR_BITS-1:0])
      preset_r <= hwdata[4*STAGES-1:0]; // see RULE1
  end

  // forwards a write still in its data phase so a following read sees it
  always_comb
  begin
    readMux = '0;
    case (haddr[PMN_ADDR_BITS-1:0])
      PMN_CTRL_ADDR[PMN_ADDR_BITS-1:0]:
      begin
        if (wrPend_r && wrAddr_r == PMN_CTRL_ADDR[PMN_ADDR_BITS-1:0])
          readMux[PMN_CTRL_BITS-1:0] = hwdata[PMN_CTRL_BITS-1:0];
        else
          readMux[PMN_CTRL_BITS-1:0] = ctrl_r;
      end
      PMN_PRESET_ADDR[PMN_ADDR_BITS-1:0]:
      begin
        if (wrPend_r && wrAddr_r == PMN_PRESET_ADDR[PMN_ADDR_BITS-1:0])
          readMux[4*STAGES-1:0] = hwdata[4*STAGES-1:0];
        else
          readMux[4*STAGES-1:0] = preset_r;
      end
      PMN_STATUS_ADDR[PMN_ADDR_BITS-1:0]:
      begin
        readMux[PMN_STAT_TC] = terminalCount_r;
        readMux[PMN_STAT_GATE] = gateLvl_r;
        readMux[PMN_STAT_CLK] = clkLvl_r;
      end
      PMN_COUNT_ADDR[PMN_ADDR_BITS-1:0]:
        readMux[4*STAGES-1:0] = countVec;
      default:
        readMux = '0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      hrdata_r <= '0;
    else if (accept && !hwrite)
      hrdata_r <= readMux;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
    else
    begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  // pins are asynchronous: three flops, level moves once two agree
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      clkSync_r <= '0;
      gateSync_r <= '0;
    end
    else
    begin
      clkSync_r <= {clkSync_r[PMN_SYNC_DEPTH-2:0], countClkPin};
      gateSync_r <= {gateSync_r[PMN_SYNC_DEPTH-2:0], gatePin}; // see RULE10
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      clkLvl_r <= 1'b0;
    else if (clkSync_r[1] == clkSync_r[2])
      clkLvl_r <= clkSync_r[2];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      gateLvl_r <= 1'b0;
    else if (gateSync_r[1] == gateSync_r[2])
      gateLvl_r <= gateSync_r[2];
  end

  assign clkRise = clkSync_r[1] && clkSync_r[2] && !clkLvl_r;

  // holding the gate high or the line low stops reload, so stages wrap
  assign gateHigh = gateLvl_r || ctrl_r[PMN_CTRL_GATEHOLD]; // see RULE9
  assign allZero = &stageZero; // see RULE16
  // reload only in the zero state and only once the gate is low
  assign reloadEn = allZero && !gateHigh
                    && !ctrl_r[PMN_CTRL_BUSLOW]; // see RULE5, RULE7

  // a stage borrows only when every lower stage sits at zero
  assign lowerZero[0] = 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++)
    begin : stageGen
      assign lowerZero[gi+1] = lowerZero[gi] && stageZero[gi]; // see RULE12
      assign presetEff[4*gi+3:4*gi] =
        pmnPresetMask(preset_r[4*gi+3:4*gi], decimalMode); // see RULE2
      pmn_stage stage (
        .clock(clock),
        .rst(rst),
        .decimalMode(decimalMode),
        .loadN(loadN),
        .clearN(clearN),
        .stepEn(clkRise && lowerZero[gi]), // see RULE11, RULE14
        .reloadEn(reloadEn), // see RULE13
        .presetVal(preset_r[4*gi+3:4*gi]),
        .count_r(countVec[4*gi+3:4*gi]),
        .isZero(stageZero[gi])
      );
    end
  endgenerate

  // one flop of lag on the pins against the internal zero flag
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      terminalCount_r <= 1'b0;
      countOut_r <= '0;
    end
    else
    begin
      terminalCount_r <= allZero; // see RULE6
      countOut_r <= countVec;
    end
  end

  preset_load_a: assert property ( // see RULE3
    @(posedge clock) disable iff (rst)
    (!loadN && clearN) |=> countVec == $past(presetEff))
    else $error("parallel load did not copy preset");

  decimal_mask_a: assert property ( // see RULE2
    @(posedge clock) disable iff (rst)
    (!loadN && clearN && decimalMode && preset_r[3:0] > 4'h9)
      |=> countVec[3:0] == {1'b0, $past(preset_r[2:0])})
    else $error("decimal preset above nine not masked");

  step_down_a: assert property ( // see RULE4
    @(posedge clock) disable iff (rst)
    (loadN && !reloadEn && clkRise && countVec[3:0] != 4'h0)
      |=> countVec[3:0] == $past(countVec[3:0]) - 4'h1)
    else $error("counted edge did not decrement");

  reload_a: assert property ( // see RULE5
    @(posedge clock) disable iff (rst)
    (loadN && allZero && !gateHigh && !ctrl_r[PMN_CTRL_BUSLOW])
      |=> countVec == $past(presetEff))
    else $error("zero state did not reload on low gate");

  gate_wait_a: assert property ( // see RULE5
    @(posedge clock) disable iff (rst)
    (loadN && allZero && gateHigh && !clkRise) |=> allZero)
    else $error("reload happened while gate high");

  tc_follow_a: assert property ( // see RULE6
    @(posedge clock) disable iff (rst)
    $rose(allZero) |=> terminalCount_r ##1 terminalCount_r == allZero)
    else $error("terminal count does not track zero state");

  hold_count_a: assert property ( // see RULE7
    @(posedge clock) disable iff (rst)
    (loadN && !clkRise && !reloadEn) |=> $stable(countVec))
    else $error("count disturbed outside zero state");

  wrap_free_a: assert property ( // see RULE9
    @(posedge clock) disable iff (rst)
    (loadN && !reloadEn && clkRise && countVec[3:0] == 4'h0)
      |=> countVec[3:0] == (decimalMode ? 4'h9 : 4'hF))
    else $error("zero stage did not wrap to maximum");

  borrow_a: assert property ( // see RULE12
    @(posedge clock) disable iff (rst)
    (STAGES > 1 && loadN && !reloadEn && clkRise
      && countVec[3:0] == 4'h0 && countVec[7:4] != 4'h0)
      |=> countVec[7:4] == $past(countVec[7:4]) - 4'h1)
    else $error("next stage missed its borrow");

  clear_zero_a: assert property ( // see RULE15
    @(posedge clock) disable iff (rst)
    (!loadN && !clearN) [*2] |-> countVec == '0)
    else $error("clear with load did not force zero");

  // bus, pin and count-hold bookkeeping around the counting chain
  ctrl_write_a: assert property ( // see RULE8
    @(posedge clock) disable iff (rst)
    (wrPend_r && wrAddr_r == PMN_CTRL_ADDR[PMN_ADDR_BITS-1:0])
      |=> ctrl_r == $past(hwdata[PMN_CTRL_BITS-1:0]))
    else $error("control write did not land");

  no_early_load_a: assert property ( // see RULE7
    @(posedge clock) disable iff (rst)
    (loadN && !allZero && !clkRise) |=> $stable(countVec))
    else $error("preset acted outside zero state");

  single_step_a: assert property ( // see RULE6
    @(posedge clock) disable iff (rst)
    clkRise |=> !clkRise)
    else $error("one counted rise stepped twice");

  tc_line_a: assert property ( // see RULE16
    @(posedge clock) disable iff (rst)
    1'b1 |=> terminalCount_r == $past(allZero))
    else $error("terminal count line lost the zero flags");

  count_pins_a: assert property ( // see RULE3
    @(posedge clock) disable iff (rst)
    1'b1 |=> countOut_r == $past(countVec))
    else $error("count pins do not follow the stages");

  gate_level_a: assert property ( // see RULE5
    @(posedge clock) disable iff (rst)
    (gateSync_r[1] == gateSync_r[2])
      |=> gateLvl_r == $past(gateSync_r[2]))
    else $error("gate level missed an agreed change");

  clock_level_a: assert property ( // see RULE4
    @(posedge clock) disable iff (rst)
    (clkSync_r[1] == clkSync_r[2])
      |=> clkLvl_r == $past(clkSync_r[2]))
    else $error("counted clock level missed an agreed change");

  read_data_a: assert property (
    @(posedge clock) disable iff (rst)
    (accept && !hwrite) |=> hrdata_r == $past(readMux))
    else $error("read data not captured");
endmodule
`default_nettype wire

/* File: test/pmn_clk_src.sv */
`default_nettype none
module pmn_clk_src
(
  input wire logic clock,
  output logic countClk,
  output logic gate
);
  timeunit 1ns;
  timeprecision 1ps;
  initial countClk = 1'b0;
  // strapped so a reload waits for the low phase of the counted clock
  assign gate = countClk;
  // low phase longer than high so a reload lands before the next rise
  task automatic pulses(input int n, input int hw);
    repeat (n)
    begin
      @(posedge clock);
      countClk <= 1'b1;
      repeat (hw) @(posedge clock);
      countClk <= 1'b0;
      repeat (hw + 3) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

/* File: test/tb_programmable_modulo_n_down_counter.sv */
`default_nettype none
`define CHK(nm, exp, act) \
  begin \
    compares++; \
    if ((act) !== (exp)) \
    begin \
      fails++; \
      $display("Error %s expected %0h seen %0h", nm, exp, act); \
    end \
  end
module tb_programmable_modulo_n_down_counter;
  timeunit 1ns;
  timeprecision 1ps;
  import pmn_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  pmnWord_t haddr = '0;
  pmnTrans_t htrans = 2'h0;
  logic hwrite = 1'b0;
  pmnWord_t hwdata = '0;
  pmnWord_t hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic countClk;
  logic gate;
  logic terminalCount_r;
  logic [7:0] countOut_r;
  logic tcPrev = 1'b0;
  int fails = 0;
  int compares = 0;
  int tcRises = 0;
  int cycles = 0;

  pmn_counter #(.STAGES(2)) DUT (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout_r), .hrdata_r(hrdata_r),
    .hreadyout_r(hreadyout_r), .hresp_r(hresp_r),
    .countClkPin(countClk), .gatePin(gate),
    .terminalCount_r(terminalCount_r), .countOut_r(countOut_r)
  );
  pmn_clk_src src (.clock(clock), .countClk(countClk), .gate(gate));

  initial forever #2.5 clock = ~clock;

  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // about 85 counted pulses of 12 to 22 cycles plus bus traffic fit well below
  always @(posedge clock)
  begin
    tcPrev <= terminalCount_r;
    if (terminalCount_r === 1'b1 && tcPrev === 1'b0)
      tcRises++;
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic xfer(input logic wr, input pmnWord_t a, input pmnWord_t d,
                      output pmnWord_t q);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= PMN_HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout_r !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout_r !== 1'b1);
    q = hrdata_r;
    `CHK("hresp", 1'b0, hresp_r)
  endtask

  task automatic wr(input pmnWord_t a, input pmnWord_t d);
    pmnWord_t q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rchk(input string nm, input pmnWord_t a, input pmnWord_t e);
    pmnWord_t q;
    xfer(1'b0, a, '0, q);
    `CHK(nm, e, q)
    if (a == PMN_COUNT_ADDR)
      `CHK("countPins", e[7:0], countOut_r)
  endtask

  // load pulse: parallel load low then high again
  task automatic ld(input pmnWord_t c, input pmnWord_t p);
    wr(PMN_PRESET_ADDR, p);
    wr(PMN_CTRL_ADDR, c & 32'hFFFF_FFFE);
    wr(PMN_CTRL_ADDR, c);
    tcRises = 0;
  endtask

  task automatic endt(input string nm);
    $display("test %s done", nm);
  endtask

  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rchk("ctrl", PMN_CTRL_ADDR, 32'h0000_0003);
    rchk("preset", PMN_PRESET_ADDR, 32'h0000_0000);
    rchk("count", PMN_COUNT_ADDR, 32'h0000_0000);
    rchk("status", PMN_STATUS_ADDR, 32'h0000_0001);
    endt("reset");
    ld(32'h3, 32'h12);
    rchk("count", PMN_COUNT_ADDR, 32'h12);
    src.pulses(3, 4);
    rchk("count", PMN_COUNT_ADDR, 32'h0F);
    src.pulses(15, 4);
    `CHK("tcPulses", 1, tcRises)
    src.pulses(18, 9);
    `CHK("tcPulses", 2, tcRises)
    rchk("count", PMN_COUNT_ADDR, 32'h12);
    endt("binary");
    ld(32'h7, 32'h12);
    src.pulses(3, 4);
    rchk("count", PMN_COUNT_ADDR, 32'h09);
    src.pulses(21, 4);
    `CHK("tcPulses", 2, tcRises)
    ld(32'h7, 32'h0E);
    src.pulses(12, 4);
    `CHK("tcPulses", 2, tcRises)
    endt("decimal");
    ld(32'h3, 32'h09);
    src.pulses(2, 4);
    wr(PMN_PRESET_ADDR, 32'h03);
    src.pulses(1, 4);
    rchk("count", PMN_COUNT_ADDR, 32'h06);
    wr(PMN_CTRL_ADDR, 32'h2);
    wr(PMN_CTRL_ADDR, 32'h3);
    rchk("count", PMN_COUNT_ADDR, 32'h03);
    src.pulses(1, 4);
    rchk("count", PMN_COUNT_ADDR, 32'h02);
    endt("reload");
    ld(32'hB, 32'h02);
    src.pulses(3, 4);
    rchk("count", PMN_COUNT_ADDR, 32'hFF);
    ld(32'hF, 32'h01);
    src.pulses(2, 4);
    rchk("count", PMN_COUNT_ADDR, 32'h99);
    ld(32'h13, 32'h01);
    src.pulses(2, 4);
    rchk("count", PMN_COUNT_ADDR, 32'hFF);
    endt("wrap");
    wr(PMN_CTRL_ADDR, 32'h0);
    rchk("count", PMN_COUNT_ADDR, 32'h00);
    src.pulses(2, 4);
    rchk("count", PMN_COUNT_ADDR, 32'h00);
    wr(PMN_COUNT_ADDR, 32'hFF);
    rchk("count", PMN_COUNT_ADDR, 32'h00);
    endt("clear");
    complete_run();
  end
endmodule
`default_nettype wire
